// ---- dsi_pkg.sv ----
// Shared constants and types of the processor serial data interface.
package dsi_pkg;

   // Port select carried on the lowest address line.
   localparam logic       PORT_DATA     = 1'b0;
   localparam logic       PORT_CTRL     = 1'b1;

   // Word sizes.
   localparam int         BUS_W         = 16;
   localparam int         WORD_W        = 12;
   localparam int         FIFO_DEPTH    = 16;
   localparam logic [3:0] LAST_BIT      = 4'hB;

   // Status register field positions.
   localparam int         ST_RX_READY   = 15;
   localparam int         ST_RX_OVERRUN = 14;
   localparam int         ST_TX_EMPTY   = 13;
   localparam int         ST_TX_UNDER   = 12;
   localparam int         ST_REF_SENSE  = 11;

   // Command register field positions and reset value.
   localparam int         CMD_SOFT_RST  = 15;
   localparam int         CMD_REF_DRIVE = 2;
   localparam logic [15:0] CMD_RESET    = 16'h0000;
   localparam logic [15:0] LATCH_RESET  = 16'h0000;

   // Destination of data-port writes.
   typedef enum logic [1:0] {
      DSI_DEST_TX_BUF  = 2'b00,
      DSI_DEST_LATCH1  = 2'b01,
      DSI_DEST_LATCH2  = 2'b10,
      DSI_DEST_LATCH3  = 2'b11
   } dsi_dest_t;

   // One bus access as seen by the board.
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [3:0]  addr;
      logic [15:0] data;
   } dsi_bus_req_t;

endpackage : dsi_pkg

// ---- dsi_serial_data_interface.sv ----
// Transmit FIFO and top level of the processor serial data interface.
//
// Functional notes
// - Destination 00 writes transmit buffer, 01 latch 1, 10 latch 2.
// - Destination bits 11 send data writes to debug latch 3.
// - Incoming serial bits are assembled into 12-bit words for the processor.
// - Status bit 15 is set when a complete received word waits.
// - Reading the receive data port clears receive-ready.
// - Received word appears on the low 12 of 16 data lines.
// - A new word arriving before the old one is read sets receive-overrun.
// - Data port reads work whatever the destination bits hold.
// - Status bit 13 is set while the transmit buffer holds no word.
// - Writing a word into the transmit buffer clears transmit-empty.
// - Low 12 data lines are shifted out as one serial bit stream.
// - Once started by a first word, stream needing a word with none supplied sets transmit-underrun.
// - Selected debug latch loads on data write; latch 1 drives connector.
// - Debug latch writes are taken at any time.
// - Reference pulse output follows command bit 2, which resets to 0.
// - Status bit 11 shows the incoming reference pulse level.
// - Command bit 15 is an active-high software reset, set then cleared.
// - Soft reset clears serial paths, FIFO and flags, not latches or command; hardware reset clears all but FIFO storage and sets serial output high.
// - Board answers only when address lines 1 to 3 match switch bits.

// Word FIFO with valid and ready on both sides.
module dsi_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic             clear,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    rd_ptr_q;
   logic [AW:0]      count_q;
   logic             push;
   logic             pop;

   // Full and empty come from the count so they never alias.
   assign in_ready  = (count_q != (AW+1)'(DEPTH));
   assign out_valid = (count_q != '0);
   assign out_data  = mem_q[rd_ptr_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Storage is written only on an accepted push.
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   // Pointers wrap at the depth, which need not be a power of two.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else if (clear) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
         end
         count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : dsi_fifo

// Board logic: bus ports, serial word paths, latches and reference pulse.
module dsi_serial_data_interface
   import dsi_pkg::*;
#(
   parameter int TX_DEPTH = FIFO_DEPTH
) (
   input  wire logic               clk,
   input  wire logic               arst_n,
   input  wire logic [2:0]         base_addr_sw,
   input  wire dsi_bus_req_t       bus_req,
   output logic      [BUS_W-1:0]   bus_data_out,
   output logic                    bus_data_oe_n,
   input  wire logic               ser_clk_in,
   input  wire logic               ser_rx_data,
   output logic                    ser_tx_data,
   input  wire logic               ref_pulse_in,
   output logic                    ref_pulse_out,
   output logic      [BUS_W-1:0]   debug_latch1,
   output logic      [BUS_W-1:0]   debug_latch2,
   output logic      [BUS_W-1:0]   debug_latch3
);

   logic [BUS_W-1:0]  cmd_q;
   logic              soft_rst;
   logic              hit;
   logic              rd_data;
   logic              wr_data;
   dsi_dest_t         dest;
   logic              ser_clk_q;
   logic              tick;
   logic [WORD_W-1:0] rx_shift_q;
   logic [3:0]        rx_cnt_q;
   logic [WORD_W-1:0] rx_word_q;
   logic              rx_ready_q;
   logic              rx_overrun_q;
   logic              rx_done;
   logic [WORD_W-1:0] tx_shift_q;
   logic [3:0]        tx_cnt_q;
   logic              tx_started_q;
   logic              tx_underrun_q;
   logic              tx_load;
   logic              fifo_in_ready;
   logic              fifo_out_valid;
   logic [WORD_W-1:0] fifo_out_data;
   logic              ref_sense_q;
   logic [BUS_W-1:0]  status;

   // Address lines 1 to 3 must match the switches before anything happens.
   assign hit      = (bus_req.addr[3:1] == base_addr_sw);
   assign rd_data  = hit && bus_req.rd && (bus_req.addr[0] == PORT_DATA);
   assign wr_data  = hit && bus_req.wr && (bus_req.addr[0] == PORT_DATA);
   assign dest     = dsi_dest_t'(cmd_q[1:0]);
   assign soft_rst = cmd_q[CMD_SOFT_RST];

   // Command register; it is the source of the software reset, so only
   // the hardware reset clears it, otherwise the reset would end itself.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cmd_q <= CMD_RESET;
      end else if (hit && bus_req.wr && (bus_req.addr[0] == PORT_CTRL)) begin
         cmd_q <= bus_req.data;
      end
   end

   // The reference pulse output simply mirrors its command bit.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ref_pulse_out <= 1'b0;
      end else begin
         ref_pulse_out <= cmd_q[CMD_REF_DRIVE];
      end
   end

   // Debug latches ignore the software reset and any serial activity.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         debug_latch1 <= LATCH_RESET;
         debug_latch2 <= LATCH_RESET;
         debug_latch3 <= LATCH_RESET;
      end else if (wr_data) begin
         case (dest)
            DSI_DEST_LATCH1: begin
               debug_latch1 <= bus_req.data;
            end
            DSI_DEST_LATCH2: begin
               debug_latch2 <= bus_req.data;
            end
            DSI_DEST_LATCH3: begin
               debug_latch3 <= bus_req.data;
            end
            default: begin
            end
         endcase
      end
   end

   // Serial clock is sampled; a rising edge marks one bit period.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ser_clk_q   <= 1'b0;
         ref_sense_q <= 1'b0;
      end else begin
         ser_clk_q   <= ser_clk_in;
         ref_sense_q <= ref_pulse_in;
      end
   end
   assign tick = ser_clk_in && !ser_clk_q;

   // Receive shifter fills from the top, so the first bit lands in bit 0.
   assign rx_done = tick && (rx_cnt_q == LAST_BIT);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_shift_q <= '0;
         rx_cnt_q   <= '0;
         rx_word_q  <= '0;
      end else if (soft_rst) begin
         rx_shift_q <= '0;
         rx_cnt_q   <= '0;
         rx_word_q  <= '0;
      end else if (tick) begin
         rx_shift_q <= {ser_rx_data, rx_shift_q[WORD_W-1:1]};
         rx_cnt_q   <= rx_done ? '0 : rx_cnt_q + 1'b1;
         if (rx_done) begin
            rx_word_q <= {ser_rx_data, rx_shift_q[WORD_W-1:1]};
         end
      end
   end

   // Ready flag: a completed word sets it even in the cycle it is read.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_ready_q   <= 1'b0;
         rx_overrun_q <= 1'b0;
      end else if (soft_rst) begin
         rx_ready_q   <= 1'b0;
         rx_overrun_q <= 1'b0;
      end else begin
         if (rx_done) begin
            rx_ready_q <= 1'b1;
         end else if (rd_data) begin
            rx_ready_q <= 1'b0;
         end
         if (rx_done && rx_ready_q && !rd_data) begin
            rx_overrun_q <= 1'b1;
         end
      end
   end

   // Transmit FIFO; when full the data-port write is dropped.
   dsi_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (TX_DEPTH)
   ) u_tx_fifo (
      .clk       (clk),
      .arst_n    (arst_n),
      .clear     (soft_rst),
      .in_valid  (wr_data && (dest == DSI_DEST_TX_BUF)),
      .in_ready  (fifo_in_ready),
      .in_data   (bus_req.data[WORD_W-1:0]),
      .out_valid (fifo_out_valid),
      .out_ready (tx_load),
      .out_data  (fifo_out_data)
   );

   // A new word is pulled only at a word boundary, which back-pressures
   // the FIFO between boundaries.
   assign tx_load = tick && (tx_cnt_q == '0) && fifo_out_valid;

   // Transmit shifter sends bit 0 first and idles high when starved.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_shift_q    <= '0;
         tx_cnt_q      <= '0;
         ser_tx_data   <= 1'b1;
         tx_started_q  <= 1'b0;
         tx_underrun_q <= 1'b0;
      end else if (soft_rst) begin
         tx_shift_q    <= '0;
         tx_cnt_q      <= '0;
         ser_tx_data   <= 1'b1;
         tx_started_q  <= 1'b0;
         tx_underrun_q <= 1'b0;
      end else if (tick) begin
         if (tx_cnt_q != '0) begin
            ser_tx_data <= tx_shift_q[0];
            tx_shift_q  <= {1'b0, tx_shift_q[WORD_W-1:1]};
            tx_cnt_q    <= tx_cnt_q - 1'b1;
         end else if (fifo_out_valid) begin
            ser_tx_data  <= fifo_out_data[0];
            tx_shift_q   <= {1'b0, fifo_out_data[WORD_W-1:1]};
            tx_cnt_q     <= LAST_BIT;
            tx_started_q <= 1'b1;
         end else begin
            ser_tx_data <= 1'b1;
            if (tx_started_q) begin
               tx_underrun_q <= 1'b1;
            end
         end
      end
   end

   // Status word; unused bits read as zero.
   always_comb begin
      status                = '0;
      status[ST_RX_READY]   = rx_ready_q;
      status[ST_RX_OVERRUN] = rx_overrun_q;
      status[ST_TX_EMPTY]   = !fifo_out_valid && fifo_in_ready;
      status[ST_TX_UNDER]   = tx_underrun_q;
      status[ST_REF_SENSE]  = ref_sense_q;
   end

   // Read data is driven for the one cycle after the read strobe.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bus_data_out  <= '0;
         bus_data_oe_n <= 1'b1;
      end else if (hit && bus_req.rd) begin
         bus_data_oe_n <= 1'b0;
         if (bus_req.addr[0] == PORT_DATA) begin
            bus_data_out <= {{(BUS_W-WORD_W){1'b0}}, rx_word_q};
         end else begin
            bus_data_out <= status;
         end
      end else begin
         bus_data_oe_n <= 1'b1;
      end
   end

endmodule : dsi_serial_data_interface

// ---- dsi_serial_data_interface_asserts.sv ----
// Port checker for the serial data interface, attached by bind.
module dsi_sdi_asserts
   import dsi_pkg::*;
(
   input wire logic         clk,
   input wire logic         arst_n,
   input wire logic [2:0]   base_addr_sw,
   input wire dsi_bus_req_t bus_req,
   input wire logic [15:0]  bus_data_out,
   input wire logic         bus_data_oe_n,
   input wire logic         ser_clk_in,
   input wire logic         ser_tx_data,
   input wire logic         ref_pulse_in,
   input wire logic         ref_pulse_out,
   input wire logic [15:0]  debug_latch1,
   input wire logic [15:0]  debug_latch2,
   input wire logic [15:0]  debug_latch3
);
   timeunit 1ns;
   timeprecision 100ps;

   logic       rd_hit, wr_ctl, wr_dat, tick, ck_q, srst_q;
   logic [1:0] dest_q;

   // Decoded bus strobes and serial tick.
   assign rd_hit = bus_req.rd && bus_req.addr[3:1] == base_addr_sw;
   assign wr_ctl = bus_req.wr && bus_req.addr == {base_addr_sw, 1'b1};
   assign wr_dat = bus_req.wr && bus_req.addr == {base_addr_sw, 1'b0};
   assign tick   = ser_clk_in && !ck_q;

   // Shadow of command fields, since they are not visible at the ports.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dest_q <= 2'h0;
         srst_q <= 1'b0;
         ck_q   <= 1'b0;
      end else begin
         ck_q <= ser_clk_in;
         if (wr_ctl) begin
            dest_q <= bus_req.data[1:0];
            srst_q <= bus_req.data[15];
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_read_answer: assert property (rd_hit |=> !bus_data_oe_n)
      else $error("matching read got no answer");
   a_drive_cause: assert property ($fell(bus_data_oe_n)
      |-> $past(rd_hit))
      else $error("bus driven without matching read");
   a_rx_upper: assert property (rd_hit && !bus_req.addr[0]
      |=> bus_data_out[15:12] == 4'h0)
      else $error("received word upper lines not zero");
   a_ref_drive: assert property (wr_ctl
      |=> ##1 ref_pulse_out == $past(bus_req.data[2], 2))
      else $error("reference output does not follow command");
   a_ref_sense: assert property (rd_hit && bus_req.addr[0]
      |=> bus_data_out[ST_REF_SENSE] == $past(ref_pulse_in, 2))
      else $error("status does not show reference input");
   a_latch1_load: assert property (wr_dat && dest_q == 2'h1
      |=> debug_latch1 == $past(bus_req.data))
      else $error("first latch not loaded");
   a_latch3_load: assert property (wr_dat && dest_q == 2'h3
      |=> debug_latch3 == $past(bus_req.data))
      else $error("third latch not loaded");
   a_latch2_cause: assert property ($changed(debug_latch2)
      |-> $past(wr_dat) && $past(dest_q) == 2'h2)
      else $error("second latch changed without its write");
   a_tx_on_tick: assert property ($changed(ser_tx_data)
      |-> $past(tick) || $past(tick, 2) || srst_q || $past(srst_q))
      else $error("serial output changed between ticks");
endmodule : dsi_sdi_asserts

bind dsi_serial_data_interface dsi_sdi_asserts u_chk (
   .clk(clk), .arst_n(arst_n), .base_addr_sw(base_addr_sw),
   .bus_req(bus_req), .bus_data_out(bus_data_out),
   .bus_data_oe_n(bus_data_oe_n), .ser_clk_in(ser_clk_in),
   .ser_tx_data(ser_tx_data), .ref_pulse_in(ref_pulse_in),
   .ref_pulse_out(ref_pulse_out), .debug_latch1(debug_latch1),
   .debug_latch2(debug_latch2), .debug_latch3(debug_latch3));

// ---- dsi_data_device.sv ----
// Behavioural serial data device: bit clock, word source and sink.
module dsi_data_device (
   input  wire logic clk,
   output logic      ser_clk_in,
   output logic      ser_rx_data,
   input  wire logic ser_tx_data
);
   timeunit 1ns;
   timeprecision 100ps;

   // Clock idles low between frames, as a real device would.
   initial begin
      ser_clk_in  = 1'b0;
      ser_rx_data = 1'b1;
   end

   // One word per call, h cycles per clock phase, low bit first.
   task automatic frame(input logic [11:0] w, input int h,
                        output logic [11:0] got);
      for (int i = 0; i < 12; i++) begin
         ser_rx_data <= w[i];
         repeat (h) @(posedge clk);
         ser_clk_in <= 1'b1;
         repeat (h) @(posedge clk);
         got[i] = ser_tx_data;
         ser_clk_in <= 1'b0;
      end
      // Line shows no stale bit once the frame is over.
      ser_rx_data <= ~w[11];
   endtask : frame
endmodule : dsi_data_device

// ---- test_dsi_serial_data_interface.sv ----
// Self-checking bench for the serial data interface.
module test_dsi_serial_data_interface
   import dsi_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [2:0] BASE = 3'h5;
   logic         clk, arst_n, sck, srx, stx, ref_in, ref_out, oe_n;
   logic [2:0]   bs;
   dsi_bus_req_t req;
   logic [15:0]  dout, l1, l2, l3, v;
   logic [11:0]  got;
   int           err_count, n_checks;

   dsi_serial_data_interface uut (.clk(clk), .arst_n(arst_n),
      .base_addr_sw(BASE), .bus_req(req), .bus_data_out(dout),
      .bus_data_oe_n(oe_n), .ser_clk_in(sck), .ser_rx_data(srx),
      .ser_tx_data(stx), .ref_pulse_in(ref_in), .ref_pulse_out(ref_out),
      .debug_latch1(l1), .debug_latch2(l2), .debug_latch3(l3));
   dsi_data_device u_dev (.clk(clk), .ser_clk_in(sck), .ser_rx_data(srx),
      .ser_tx_data(stx));

   task automatic chk(input string nm, input logic [15:0] s, e);
      n_checks++;
      if (s !== e) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", nm, e, s);
      end
   endtask : chk

   // Two extra idle edges let registered effects land before checks.
   task automatic wr(input logic p, input logic [15:0] d);
      req <= '{rd: 1'b0, wr: 1'b1, addr: {bs, p}, data: d};
      @(posedge clk);
      req.wr <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : wr

   // An unanswered read returns unknown so it can never match data.
   task automatic rd(input logic p, output logic [15:0] d);
      req <= '{rd: 1'b1, wr: 1'b0, addr: {bs, p}, data: 16'h0000};
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      d = oe_n ? 16'hxxxx : dout;
      @(posedge clk);
   endtask : rd

   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test

   // Free-running system clock.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Cuts a hang short; the tests need about 1800 cycles.
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      end_of_test();
   end

   // Test sequence.
   initial begin
      arst_n = 1'b0;
      bs = BASE;
      ref_in = 1'b0;
      req = '0;
      err_count = 0;
      n_checks = 0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      rd(1'b1, v);
      chk("status", v, 16'h2000);
      chk("latch1", l1, 16'h0000);
      $display("test reset done");
      for (int i = 1; i < 4; i++) begin
         wr(1'b1, 16'(i));
         wr(1'b0, 16'h0A50 + 16'(i));
      end
      wr(1'b1, 16'h0000);
      chk("latch1", l1, 16'h0A51);
      chk("latch2", l2, 16'h0A52);
      chk("latch3", l3, 16'h0A53);
      $display("test latches done");
      ref_in <= 1'b1;
      wr(1'b1, 16'h0004);
      chk("ref_out", {15'h0000, ref_out}, 16'h0001);
      rd(1'b1, v);
      chk("status", v, 16'h2800);
      ref_in <= 1'b0;
      wr(1'b1, 16'h0000);
      chk("ref_out", {15'h0000, ref_out}, 16'h0000);
      $display("test reference done");
      // The seventeenth word finds the buffer full and is dropped.
      for (int i = 0; i < 17; i++)
         wr(1'b0, 16'(i * 'h0F1 + 1));
      rd(1'b1, v);
      chk("status", v, 16'h0000);
      for (int i = 0; i < 17; i++) begin
         u_dev.frame(12'(i * 'h2B + 'h300), 3 + i % 2, got);
         chk("tx word", {4'h0, got},
             i < 16 ? 16'(i * 'h0F1 + 1) : 16'h0FFF);
         rd(1'b1, v);
         chk("status", v, 16'h8000 | (i > 14 ? 16'h2000 : 16'h0000)
             | (i == 16 ? 16'h1000 : 16'h0000));
         rd(1'b0, v);
         chk("rx word", v, 16'(i * 'h2B + 'h300));
      end
      rd(1'b1, v);
      chk("status", v, 16'h3000);
      $display("test stream done");
      wr(1'b1, 16'h0003);
      u_dev.frame(12'h123, 3, got);
      // A status read between frames must not clear the ready flag.
      rd(1'b1, v);
      chk("status", v, 16'hB000);
      u_dev.frame(12'h456, 5, got);
      rd(1'b1, v);
      chk("status", v, 16'hF000);
      rd(1'b0, v);
      chk("rx word", v, 16'h0456);
      rd(1'b1, v);
      chk("status", v, 16'h7000);
      wr(1'b1, 16'h8000);
      wr(1'b1, 16'h0000);
      rd(1'b1, v);
      chk("status", v, 16'h2000);
      chk("latch3", l3, 16'h0A53);
      $display("test overrun and soft reset done");
      bs = ~BASE;
      wr(1'b1, 16'h0004);
      rd(1'b1, v);
      chk("miss read", v, 16'hxxxx);
      chk("ref_out", {15'h0000, ref_out}, 16'h0000);
      bs = BASE;
      $display("test address decode done");
      // A hardware reset in mid-run must clear the latches as well.
      arst_n <= 1'b0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      chk("latch3", l3, 16'h0000);
      chk("latch1", l1, 16'h0000);
      $display("test hardware reset done");
      end_of_test();
   end
endmodule : test_dsi_serial_data_interface
